// ### clock_routing_defs.svh
// Register offsets, field positions, reset values and code points
// Included by the routing control package users; definitions only
`ifndef CLOCK_ROUTING_DEFS_SVH
`define CLOCK_ROUTING_DEFS_SVH

`define VCO_RANGE_OFFSET      8'h06
`define PIN_FUNCTION_OFFSET   8'h0a
`define SOURCE_TYPE_OFFSET    8'h0b
`define MATRIX_A_BASE_OFFSET  8'h1b
`define MATRIX_A_COUNT        6

`define VCO_RANGE_LSB         5
`define VCO_RANGE_RESET       3'h7
`define PIN_A_CONFIG_LSB      6
`define INPUT_SELECT_BIT      4
`define PIN_B_CONFIG_LSB      2
`define PIN_FUNCTION_RESET    8'h00
`define SOURCE_TYPE_LSB       6
`define SOURCE_TYPE_RESET     2'h0

`define PIN_CFG_POWER_DOWN    2'h0
`define PIN_CFG_TEST_BYPASS   2'h1
`define PIN_CFG_INPUT_SELECT  2'h2
`define PIN_CFG_FORCE_LOW     2'h0
`define PIN_CFG_HIGH_Z        2'h1

`define SRC_CRYSTAL           2'h0
`define SRC_SINGLE_ENDED      2'h1
`define SRC_DIFFERENTIAL      2'h2

`define MATRIX_BYPASS         3'h0
`define MATRIX_PLL1           3'h1
`define MATRIX_PLL2_PLAIN     3'h2
`define MATRIX_PLL2_SPREAD    3'h3
`define MATRIX_PLL3           3'h4
`define MATRIX_RESET          18'h0_9262

`endif

// ### clock_routing_pkg.sv
// Types shared by the clock routing control block
// Constants live in clock_routing_defs.svh
package clock_routing_pkg;
  typedef logic [2:0] matrix_code_t;
  typedef logic [1:0] pin_config_t;
  typedef logic [1:0] source_type_t;
  typedef logic [7:0] reg_byte_t;
endpackage

// ### synth_clock_routing_pin_control.sv
// Configuration and pin-function control of a three-PLL clock synthesizer
// Assumes a byte register port decoded by the management bus engine
//
// Function
// - Each PLL range bit picks 80-200 MHz at 0 and 180-300 MHz at 1.
// - The range bits come up at 1, the high-speed range, after reset.
// - Each of six post-dividers takes its source from a 3-bit matrix code.
// - Spread bypass, pin A power-down or test bypass powers the spread path down and holds it low.
// - Pin A config 00 with pin A low powers down and tri-states outputs.
// - Pin A config 01 with pin A low bypasses and powers down the PLLs.
// - Pin A config 10 makes pin A the input selector over the register bit.
// - Pin A power-down wins over forcing or tri-state asked by pin B.
// - Pin input selection is ignored for crystal or differential input.
// - Pin B config 00 with pin B low forces outputs to inactive level.
// - Pin B config 01 with pin B low tri-states every output.
// - The register select bit picks input 0 when clear, input 1 when set.
// - The register select bit is ignored for crystal or differential input.
// - The source type field picks crystal, single-ended or differential.
`timescale 1ns/1ps
`include "clock_routing_defs.svh"

module synth_clock_routing_pin_control #(
  parameter int DIVIDERS = `MATRIX_A_COUNT
) (
  input  wire logic        core_clk,               // 200 MHz clock
  input  wire logic        reset,                  // Async, active high
  input  wire logic [7:0]  reg_addr,               // Register byte offset
  input  wire logic [7:0]  reg_wdata,              // Write byte
  input  wire logic        reg_wr,                 // Write strobe
  input  wire logic        reg_rd,                 // Read strobe
  output logic      [7:0]  reg_rdata,              // Read byte, next cycle
  input  wire logic        control_pin_a,          // External pin A
  input  wire logic        control_pin_b,          // External pin B
  input  wire logic        spread_bypass,          // Spread bypass setting
  output logic      [2:0]  vco_high_range,         // Per-PLL range
  output logic      [2:0]  pll_power_down,         // Per-PLL power-down
  output logic             input_stage_power_down, // Input stage off
  output logic             divider_bypass,         // Test bypass of M and P
  output logic             clock_input_sel,        // 0 input zero, 1 one
  output logic [3*DIVIDERS-1:0] divider_source,    // Matrix codes in use
  output logic [DIVIDERS-1:0]   divider_active,    // Divider path enabled
  output logic             spread_power_down,      // Spread path off
  output logic             spread_output_low,      // Spread output held low
  output logic             outputs_high_z,         // All outputs 3-state
  output logic             outputs_inactive        // Outputs forced inactive
);

  typedef clock_routing_pkg::matrix_code_t matrix_code_t;

  logic [2:0]              vco_range;
  logic [7:0]              pin_function;
  logic [1:0]              source_type;
  logic [3*DIVIDERS-1:0]   matrix_a;
  logic [2:0]              sync_a;
  logic [2:0]              sync_b;
  logic                    pin_a_level;
  logic                    pin_b_level;
  logic                    next_power_down;
  logic                    next_bypass;
  logic                    next_select;
  logic                    next_high_z;
  logic                    next_inactive;
  logic [7:0]              next_rdata;
  logic                    next_spread_off;

  function automatic logic matrix_valid(input matrix_code_t code);
    matrix_valid = (code <= `MATRIX_PLL3);
  endfunction

  // Write strobe aimed at one register offset
  function automatic logic write_hit(input logic [7:0] wr_addr,
                                     input logic       wr_strobe,
                                     input logic [7:0] offset);
    write_hit = wr_strobe && (wr_addr == offset);
  endfunction

  // Register writes
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      vco_range <= `VCO_RANGE_RESET;
    end
    else if (write_hit(reg_addr, reg_wr, `VCO_RANGE_OFFSET))
    begin
      vco_range <= reg_wdata[`VCO_RANGE_LSB +: 3];
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_function <= `PIN_FUNCTION_RESET;
    end
    else if (write_hit(reg_addr, reg_wr, `PIN_FUNCTION_OFFSET))
    begin
      pin_function <= {reg_wdata[7:2], 2'h0};
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      source_type <= `SOURCE_TYPE_RESET;
    end
    else if (write_hit(reg_addr, reg_wr, `SOURCE_TYPE_OFFSET))
    begin
      source_type <= reg_wdata[`SOURCE_TYPE_LSB +: 2];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DIVIDERS; gi++)
    begin : g_matrix
      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
        begin
          matrix_a[3*gi +: 3] <= 3'(`MATRIX_RESET >> (3*gi));
        end
        else if (write_hit(reg_addr, reg_wr, `MATRIX_A_BASE_OFFSET + 8'(gi)))
        begin
          matrix_a[3*gi +: 3] <= reg_wdata[2:0];
        end
      end

      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
        begin
          divider_source[3*gi +: 3] <= 3'(`MATRIX_RESET >> (3*gi));
        end
        else
        begin
          // Test bypass routes every divider to the input clock
          divider_source[3*gi +: 3] <= next_bypass ? `MATRIX_BYPASS
                                       : matrix_a[3*gi +: 3];
        end
      end

      // Reserved codes leave the divider path idle
      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
        begin
          divider_active[gi] <= 1'b0;
        end
        else
        begin
          divider_active[gi] <= matrix_valid(matrix_a[3*gi +: 3])
                                && !next_power_down;
        end
      end
    end
  endgenerate

  // Register reads
  always_comb
  begin
    next_rdata = 8'h00;
    if (reg_addr == `VCO_RANGE_OFFSET)
    begin
      next_rdata[`VCO_RANGE_LSB +: 3] = vco_range;
    end
    else if (reg_addr == `PIN_FUNCTION_OFFSET)
    begin
      next_rdata = pin_function;
    end
    else if (reg_addr == `SOURCE_TYPE_OFFSET)
    begin
      next_rdata[`SOURCE_TYPE_LSB +: 2] = source_type;
    end
    else if (reg_addr >= `MATRIX_A_BASE_OFFSET
             && reg_addr < `MATRIX_A_BASE_OFFSET + 8'(DIVIDERS))
    begin
      next_rdata[2:0] = matrix_a[3*(reg_addr - `MATRIX_A_BASE_OFFSET) +: 3];
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      reg_rdata <= next_rdata;
    end
  end

  // Pin synchronisers, level taken once stages two and three agree
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      sync_a      <= 3'h7;
      sync_b      <= 3'h7;
      pin_a_level <= 1'b1;
      pin_b_level <= 1'b1;
    end
    else
    begin
      sync_a <= {sync_a[1:0], control_pin_a};
      sync_b <= {sync_b[1:0], control_pin_b};
      if (sync_a[1] == sync_a[2])
      begin
        pin_a_level <= sync_a[2];
      end
      if (sync_b[1] == sync_b[2])
      begin
        pin_b_level <= sync_b[2];
      end
    end
  end

  // Pin function decode
  always_comb
  begin
    next_power_down = 1'b0;
    next_bypass     = 1'b0;
    next_select     = 1'b0;
    next_high_z     = 1'b0;
    next_inactive   = 1'b0;
    case (pin_function[`PIN_A_CONFIG_LSB +: 2])
      `PIN_CFG_POWER_DOWN:  next_power_down = !pin_a_level;
      `PIN_CFG_TEST_BYPASS: next_bypass     = !pin_a_level;
      default:              next_bypass     = 1'b0;
    endcase
    if (source_type == `SRC_SINGLE_ENDED)
    begin
      if (pin_function[`PIN_A_CONFIG_LSB +: 2] == `PIN_CFG_INPUT_SELECT)
      begin
        next_select = pin_a_level;
      end
      else
      begin
        next_select = pin_function[`INPUT_SELECT_BIT];
      end
    end
    if (next_power_down)
    begin
      next_high_z = 1'b1;
    end
    else if (!pin_b_level)
    begin
      case (pin_function[`PIN_B_CONFIG_LSB +: 2])
        `PIN_CFG_FORCE_LOW: next_inactive = 1'b1;
        `PIN_CFG_HIGH_Z:    next_high_z   = 1'b1;
        default:            next_inactive = 1'b0;
      endcase
    end
    next_spread_off = spread_bypass || next_power_down || next_bypass;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pll_power_down         <= 3'h0;
      input_stage_power_down <= 1'b0;
      divider_bypass         <= 1'b0;
      outputs_high_z         <= 1'b0;
      outputs_inactive       <= 1'b0;
    end
    else
    begin
      pll_power_down         <= {3{next_power_down | next_bypass}};
      input_stage_power_down <= next_power_down;
      divider_bypass         <= next_bypass;
      outputs_high_z         <= next_high_z;
      outputs_inactive       <= next_inactive;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      vco_high_range <= `VCO_RANGE_RESET;
    end
    else
    begin
      vco_high_range <= vco_range;
    end
  end

  // Input choice follows its register or pin one edge later
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      clock_input_sel <= 1'b0;
    end
    else
    begin
      clock_input_sel <= next_select;
    end
  end

  // Spread path off on its own bypass, full power-down or test bypass
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      spread_power_down <= 1'b0;
      spread_output_low <= 1'b0;
    end
    else
    begin
      spread_power_down <= next_spread_off;
      spread_output_low <= next_spread_off;
    end
  end

endmodule

// ### routing_asserts.sv
// Checker for the clock routing control block, bound to its top module
// Assumes a one-cycle register write and a 4-5 edge pin path
`timescale 1ns/1ps
module routing_asserts #(
  parameter int DIVIDERS = 6
) (
  input wire logic core_clk,                     // Clock
  input wire logic reset,                        // Reset
  input wire logic [7:0] reg_addr,               // Offset
  input wire logic [7:0] reg_wdata,              // Data
  input wire logic reg_wr,                       // Write
  input wire logic control_pin_a,                // Pin A
  input wire logic control_pin_b,                // Pin B
  input wire logic spread_bypass,                // Bypass
  input wire logic [2:0] vco_high_range,         // Range
  input wire logic [2:0] pll_power_down,         // PLL off
  input wire logic input_stage_power_down,       // Input off
  input wire logic divider_bypass,               // Test
  input wire logic clock_input_sel,              // Pick
  input wire logic [3*DIVIDERS-1:0] divider_source, // Codes
  input wire logic spread_power_down,            // Spread off
  input wire logic outputs_high_z,               // 3-state
  input wire logic outputs_inactive              // Forced
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [1:0] src_q;
  logic [1:0] cfg_b;
  // Shadows of the source type and pin B fields
  always_ff @(posedge core_clk or posedge reset)
    if (reset) src_q <= 2'h0;
    else if (reg_wr && reg_addr == 8'h0b) src_q <= reg_wdata[7:6];
  always_ff @(posedge core_clk or posedge reset)
    if (reset) cfg_b <= 2'h0;
    else if (reg_wr && reg_addr == 8'h0a) cfg_b <= reg_wdata[3:2];
  sequence s_b_low(logic [1:0] c);
    (control_pin_a && !control_pin_b && cfg_b == c) [*8];
  endsequence
  property p_range;
    logic [2:0] v;
    (reg_wr && reg_addr == 8'h06, v = reg_wdata[7:5]) |->
      ##2 vco_high_range == v;
  endproperty
  property p_reset;
    $fell(reset) |-> vco_high_range == 3'h7 && divider_source == 18'h0_9262;
  endproperty
  property p_pd;
    input_stage_power_down |-> outputs_high_z && pll_power_down == 3'h7;
  endproperty
  property p_prio;
    input_stage_power_down |-> !outputs_inactive;
  endproperty
  property p_bypass;
    divider_bypass |-> pll_power_down == 3'h7 && divider_source == '0;
  endproperty
  property p_spread;
    spread_bypass |=> spread_power_down;
  endproperty
  property p_sel;
    clock_input_sel |-> $past(src_q) == 2'h1;
  endproperty
  property p_force;
    s_b_low(2'h0) |-> outputs_inactive;
  endproperty
  property p_hiz;
    s_b_low(2'h1) |-> outputs_high_z;
  endproperty
  a_range: assert property (p_range) else $error("range wrong");
  a_reset: assert property (p_reset) else $error("defaults wrong");
  a_pd: assert property (p_pd) else $error("power-down wrong");
  a_prio: assert property (p_prio) else $error("priority wrong");
  a_bypass: assert property (p_bypass) else $error("bypass wrong");
  a_spread: assert property (p_spread) else $error("spread wrong");
  a_sel: assert property (p_sel) else $error("select wrong");
  a_force: assert property (p_force) else $error("force wrong");
  a_hiz: assert property (p_hiz) else $error("3-state wrong");
endmodule
bind synth_clock_routing_pin_control routing_asserts #(
  .DIVIDERS(DIVIDERS)
) routing_asserts_inst (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
  .control_pin_a, .control_pin_b, .spread_bypass, .vco_high_range,
  .pll_power_down, .input_stage_power_down, .divider_bypass,
  .clock_input_sel, .divider_source, .spread_power_down, .outputs_high_z,
  .outputs_inactive);

// ### pin_host_model.sv
// Host driving the two control pins as a clocked controller would
// Assumes the bench gives the wanted levels
`timescale 1ns/1ps
module pin_host_model (
  input  wire logic core_clk, // Clock
  input  wire logic want_a,   // Level for pin A
  input  wire logic want_b,   // Level for pin B
  output logic      pin_a,    // Pin A
  output logic      pin_b     // Pin B
);
  initial {pin_a, pin_b} = 2'b11;
  always @(posedge core_clk) {pin_a, pin_b} <= #1 {want_a, want_b};
endmodule

// ### testbench.sv
// Self-checking bench for the clock routing control block
// Assumes the pin host model and the checker are compiled before it
`timescale 1ns/1ps
module testbench;
  logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, spread_bypass = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic want_a = 1, want_b = 1, control_pin_a, control_pin_b;
  logic [2:0] vco_high_range, pll_power_down;
  logic [17:0] divider_source;
  logic [5:0] divider_active;
  logic input_stage_power_down, divider_bypass, clock_input_sel;
  logic spread_power_down, outputs_high_z, outputs_inactive, spread_output_low;
  logic [31:0] seed = 32'h6ba5;
  int fails = 0, n_tests = 0, cycles = 0, d;
  int rng = 7, pcfg = 0, src = 0, mat[6] = '{2, 4, 1, 1, 1, 1};
  synth_clock_routing_pin_control synth_clock_routing_pin_control_inst (
    .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .control_pin_a, .control_pin_b, .spread_bypass, .vco_high_range,
    .pll_power_down, .input_stage_power_down, .divider_bypass,
    .clock_input_sel, .divider_source, .divider_active, .spread_power_down,
    .spread_output_low, .outputs_high_z, .outputs_inactive);
  pin_host_model pin_host_model_inst (.core_clk, .want_a, .want_b,
    .pin_a(control_pin_a), .pin_b(control_pin_b));
  always #2.5 core_clk = ~core_clk;
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    @(posedge core_clk) #1 reg_wr = 0;
    @(posedge core_clk) #1;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1;
    @(posedge core_clk) #1 reg_rd = 0;
    check("reg_rdata", reg_rdata, exp);
    @(posedge core_clk) #1;
  endtask
  // Reference model of all outputs but reg_rdata after pins and registers settle
  task automatic verify();
    logic pd, tm;
    logic [17:0] ds;
    logic [5:0] da;
    repeat (8) @(posedge core_clk);
    #1;
    pd = !want_a && pcfg[7:6] == 0;
    tm = !want_a && pcfg[7:6] == 1;
    for (int i = 0; i < 6; i++)
    begin
      ds[3*i+:3] = tm ? 3'h0 : 3'(mat[i]);
      da[i] = !pd && mat[i] <= 4;
    end
    check("range", vco_high_range, rng);
    check("pll_pd", pll_power_down, (pd | tm) ? 7 : 0);
    check("input_pd", input_stage_power_down, pd);
    check("bypass", divider_bypass, tm);
    check("sel", clock_input_sel, src == 1 &&
      (pcfg[7:6] == 2 ? want_a : pcfg[4]));
    check("source", divider_source, ds);
    check("active", divider_active, da);
    check("spread", spread_power_down, spread_bypass | pd | tm);
    check("spread_low", spread_output_low, spread_bypass | pd | tm);
    check("hiz", outputs_high_z, pd || !want_b && pcfg[3:2] == 1);
    check("force", outputs_inactive, !pd && !want_b && pcfg[3:2] == 0);
  endtask
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      complete_run();
    end
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    #1 reset = 0;
    verify();
    rd(8'h06, 8'he0);
    rd(8'h0a, 8'h00);
    rd(8'h40, 8'h00);
    $display("Test reset done");
    repeat (4)
    begin
      seed = xs(seed);
      rng = seed[2:0];
      wr(8'h06, {seed[2:0], 5'h0});
      rd(8'h06, {seed[2:0], 5'h0});
      verify();
    end
    $display("Test range done");
    for (int c = 0; c < 8; c++)
    begin
      seed = xs(seed);
      d = seed % 6;
      mat[d] = c;
      wr(8'(8'h1b + d), 8'(c));
      rd(8'(8'h1b + d), 8'(c));
      verify();
    end
    $display("Test matrix done");
    for (int s = 0; s < 10; s++)
    begin
      src = s < 6 ? s / 2 : 1 + (s - 6) / 2;
      pcfg = s < 6 ? (s % 2) << 4 : 8'h80;
      want_a = s[0];
      wr(8'h0b, 8'(src << 6));
      wr(8'h0a, 8'(pcfg));
      verify();
    end
    $display("Test select done");
    for (int k = 0; k < 32; k++)
    begin
      seed = xs(seed);
      spread_bypass = seed[0];
      pcfg = (k % 4) << 6 | (k / 4 % 4) << 2;
      want_a = k[4];
      want_b = 0;
      wr(8'h0a, 8'(pcfg));
      verify();
    end
    $display("Test pins done");
    complete_run();
  end
endmodule
